// >>> verilog/mcc_counters.sv
// Three statistics counters: multicast octets in and out, and frames
// sent after several collisions. Assumes frame reports and register
// strobes come from logic on clk, one cycle wide each.

`timescale 1ns/10ps

// *****************************************************************
// One counter with write port and threshold detection
// *****************************************************************
module mcc_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic swReset,
  input wire logic inc,
  input wire logic [31:0] amount,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  output logic [31:0] count,
  output logic hit
);
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic hit_q;
  logic hit_d;
  logic [32:0] sum;

  // Next count: reset, then write, then frame increment
  always_comb begin
    sum = {1'b0, count_q} + {1'b0, amount};
    count_d = count_q;
    hit_d = 1'b0;
    if (swReset) begin
      count_d = mcc_pkg::CNT_RESET;
    end else if (wrEn) begin
      count_d = wrData;
    end else if (inc) begin
      count_d = sum[31:0]; // Wraps past all ones
      hit_d = (count_q < mcc_pkg::STATS_THRESHOLD) &&
              (sum >= {1'b0, mcc_pkg::STATS_THRESHOLD});
    end
  end

  // Count and hit registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= mcc_pkg::CNT_RESET;
      hit_q <= 1'b0;
    end else begin
      count_q <= count_d;
      hit_q <= hit_d;
    end
  end

  // Registered outputs
  assign count = count_q;
  assign hit = hit_q;
endmodule

// *****************************************************************
// Top: frame qualification, register access, event output
// *****************************************************************
module mcc_counters (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic swReset,
  input wire logic statsGlobalEnable,
  input wire logic [2:0] statsCounterMask,
  input wire mcc_pkg::mcc_frame_t rxFrame,
  input wire mcc_pkg::mcc_frame_t txFrame,
  input wire mcc_pkg::mcc_reg_req_t regReq,
  output logic [31:0] regRdata,
  output logic regRdValid,
  output logic statsThresholdEvent
);
  logic rxOctInc;
  logic txOctInc;
  logic mcolInc;
  logic [31:0] rxAmount;
  logic [31:0] txAmount;
  logic wrRx;
  logic wrTx;
  logic wrMcol;
  logic [31:0] rxOctCount;
  logic [31:0] txOctCount;
  logic [31:0] mcolCount;
  logic rxHit;
  logic txHit;
  logic mcolHit;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rdValid_q;
  logic rdValid_d;

  // Qualify finished frames; failed frames never count
  always_comb begin
    rxOctInc = rxFrame.done && rxFrame.ok && rxFrame.groupDest &&
               !rxFrame.broadcastDest && statsGlobalEnable &&
               !statsCounterMask[mcc_pkg::MASK_RX_OCT];
    txOctInc = txFrame.done && txFrame.ok && txFrame.groupDest &&
               !txFrame.broadcastDest && statsGlobalEnable &&
               !statsCounterMask[mcc_pkg::MASK_TX_OCT];
    mcolInc = txFrame.done && txFrame.ok &&
              (txFrame.collisions >= mcc_pkg::MULTI_COL_MIN) &&
              statsGlobalEnable &&
              !statsCounterMask[mcc_pkg::MASK_MCOL];
  end

  // Octet amounts with the four tag octets added for tagged frames only
  always_comb begin
    rxAmount = {16'h0000, rxFrame.octets} +
               (rxFrame.vlanTagged ? mcc_pkg::VLAN_TAG_OCTETS :
                                     mcc_pkg::CNT_RESET);
    txAmount = {16'h0000, txFrame.octets} +
               (txFrame.vlanTagged ? mcc_pkg::VLAN_TAG_OCTETS :
                                     mcc_pkg::CNT_RESET);
  end

  // Write decode
  always_comb begin
    wrRx = regReq.write && (regReq.addr == mcc_pkg::MCAST_RX_OCT_OFS);
    wrTx = regReq.write && (regReq.addr == mcc_pkg::MCAST_TX_OCT_OFS);
    wrMcol = regReq.write && (regReq.addr == mcc_pkg::MULTI_COL_OFS);
  end

  // Counter instances
  mcc_counter uRxOct (
    .clk(clk),
    .rst_n(rst_n),
    .swReset(swReset),
    .inc(rxOctInc),
    .amount(rxAmount),
    .wrEn(wrRx),
    .wrData(regReq.wdata),
    .count(rxOctCount),
    .hit(rxHit)
  );

  mcc_counter uTxOct (
    .clk(clk),
    .rst_n(rst_n),
    .swReset(swReset),
    .inc(txOctInc),
    .amount(txAmount),
    .wrEn(wrTx),
    .wrData(regReq.wdata),
    .count(txOctCount),
    .hit(txHit)
  );

  mcc_counter uMcol (
    .clk(clk),
    .rst_n(rst_n),
    .swReset(swReset),
    .inc(mcolInc),
    .amount(mcc_pkg::ONE_FRAME),
    .wrEn(wrMcol),
    .wrData(regReq.wdata),
    .count(mcolCount),
    .hit(mcolHit)
  );

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    rdValid_d = regReq.read;
    if (regReq.read) begin
      case (regReq.addr)
        mcc_pkg::MCAST_RX_OCT_OFS: rdata_d = rxOctCount;
        mcc_pkg::MCAST_TX_OCT_OFS: rdata_d = txOctCount;
        mcc_pkg::MULTI_COL_OFS: rdata_d = mcolCount;
        default: rdata_d = mcc_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  // Read data registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= mcc_pkg::RDATA_UNMAPPED;
      rdValid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rdValid_q <= rdValid_d;
    end
  end

  // Outputs straight from flip-flops, event is an OR of hit flops
  assign regRdata = rdata_q;
  assign regRdValid = rdValid_q;
  assign statsThresholdEvent = rxHit || txHit || mcolHit;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // No software clear or register write competing with a frame
  logic quiet;
  assign quiet = !swReset && !regReq.write;

  property p_rx_add;
    rxOctInc && quiet |=> rxOctCount == $past(rxOctCount) + $past(rxAmount);
  endproperty
  a_rx_add: assert property (p_rx_add)
    else $error("rx octets not added");

  property p_tx_vlan;
    txOctInc && quiet && txFrame.vlanTagged |=>
      txOctCount - $past(txOctCount) ==
      {16'h0000, $past(txFrame.octets)} + mcc_pkg::VLAN_TAG_OCTETS;
  endproperty
  a_tx_vlan: assert property (p_tx_vlan)
    else $error("tag octets missing");

  property p_tx_wrap;
    txOctInc && quiet &&
      ({1'b0, txOctCount} + {1'b0, txAmount}) > {1'b0, mcc_pkg::CNT_MAX} |=>
      txOctCount < $past(txAmount);
  endproperty
  a_tx_wrap: assert property (p_tx_wrap)
    else $error("tx octets no wrap");

  property p_tx_gate;
    quiet && (!statsGlobalEnable ||
      statsCounterMask[mcc_pkg::MASK_TX_OCT]) |=> $stable(txOctCount);
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("tx octets ungated");

  property p_mcol_inc;
    mcolInc && quiet |=> mcolCount == $past(mcolCount) + mcc_pkg::ONE_FRAME;
  endproperty
  a_mcol_inc: assert property (p_mcol_inc)
    else $error("collision no inc");

  property p_mcol_wrap;
    mcolInc && quiet && mcolCount == mcc_pkg::CNT_MAX |=>
      mcolCount == mcc_pkg::CNT_RESET;
  endproperty
  a_mcol_wrap: assert property (p_mcol_wrap)
    else $error("collision no wrap");

  property p_mcol_gate;
    quiet && (!statsGlobalEnable ||
      statsCounterMask[mcc_pkg::MASK_MCOL]) |=> $stable(mcolCount);
  endproperty
  a_mcol_gate: assert property (p_mcol_gate)
    else $error("collision ungated");

  sequence s_tx_cross;
    txOctInc && quiet && txOctCount < mcc_pkg::STATS_THRESHOLD ##1
      txOctCount >= mcc_pkg::STATS_THRESHOLD;
  endsequence
  property p_tx_event;
    s_tx_cross |-> statsThresholdEvent;
  endproperty
  a_tx_event: assert property (p_tx_event)
    else $error("tx event missing");

  sequence s_mcol_cross;
    mcolInc && quiet &&
      mcolCount == mcc_pkg::STATS_THRESHOLD - mcc_pkg::ONE_FRAME;
  endsequence
  property p_mcol_event;
    s_mcol_cross |=> statsThresholdEvent ##1 !mcolHit;
  endproperty
  a_mcol_event: assert property (p_mcol_event)
    else $error("mcol event bad");

  property p_rx_fail;
    rxFrame.done && !rxFrame.ok && !txFrame.done && quiet |=>
      $stable(rxOctCount) && $stable(txOctCount) && $stable(mcolCount);
  endproperty
  a_rx_fail: assert property (p_rx_fail)
    else $error("failed frame counted");

  property p_rx_gate;
    quiet && (!statsGlobalEnable ||
      statsCounterMask[mcc_pkg::MASK_RX_OCT]) |=> $stable(rxOctCount);
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("rx octets ungated");

  property p_tx_bcast;
    txFrame.done && txFrame.broadcastDest && quiet |=> $stable(txOctCount);
  endproperty
  a_tx_bcast: assert property (p_tx_bcast)
    else $error("broadcast counted");
endmodule

// >>> verilog/mcc_pkg.sv
// Constants and carrier types for the multicast and collision counters.
// Assumes a MAC on the same clock that reports each finished frame once.

package mcc_pkg;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] MCAST_RX_OCT_OFS = 8'hAC;
  localparam logic [7:0] MCAST_TX_OCT_OFS = 8'hD4;
  localparam logic [7:0] MULTI_COL_OFS = 8'hD8;

  // ***************************************************************
  // Counter values
  // ***************************************************************
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] STATS_THRESHOLD = 32'hC000_0000;
  localparam logic [31:0] VLAN_TAG_OCTETS = 32'h0000_0004;
  localparam logic [31:0] ONE_FRAME = 32'h0000_0001;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
  localparam logic [4:0] MULTI_COL_MIN = 5'h02;

  // ***************************************************************
  // Bit positions in the counter mask input
  // ***************************************************************
  localparam int MASK_RX_OCT = 0;
  localparam int MASK_TX_OCT = 1;
  localparam int MASK_MCOL = 2;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic done;
    logic ok;
    logic groupDest;
    logic broadcastDest;
    logic vlanTagged;
    logic [4:0] collisions;
    logic [15:0] octets;
  } mcc_frame_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mcc_reg_req_t;

endpackage

// >>> dv/mcc_counters_tb.sv
// Self-checking bench for the multicast and collision counters.
// Assumes the design files in verilog/ are compiled before it.

`timescale 1ns/10ps

module mcc_counters_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic swReset = 1'b0;
  logic statsGlobalEnable = 1'b1;
  logic [2:0] statsCounterMask = 3'h0;
  mcc_pkg::mcc_frame_t rxFrame = '0;
  mcc_pkg::mcc_frame_t txFrame = '0;
  mcc_pkg::mcc_reg_req_t regReq = '0;
  logic [31:0] regRdata;
  logic regRdValid;
  logic statsThresholdEvent;
  int fails = 0;
  int numChecks = 0;
  // Expected counts after each of the four enable steps
  logic [31:0] expRx [4] = '{32'h0000_00A4, 32'h0000_00B4, 32'h0000_00C4,
                             32'h0000_00C4};
  logic [31:0] expTx [4] = '{32'h0000_0050, 32'h0000_0050, 32'h0000_0060,
                             32'h0000_0060};
  logic [31:0] expCol [4] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0002,
                              32'h0000_0002};

  // ****************************************************
  // Clock, design and helpers
  // ****************************************************
  always #20 clk = ~clk;

  mcc_counters u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .swReset(swReset),
    .statsGlobalEnable(statsGlobalEnable),
    .statsCounterMask(statsCounterMask),
    .rxFrame(rxFrame),
    .txFrame(txFrame),
    .regReq(regReq),
    .regRdata(regRdata),
    .regRdValid(regRdValid),
    .statsThresholdEvent(statsThresholdEvent)
  );

  // Compare and count
  task automatic check(logic [31:0] seen, logic [31:0] exp, string msg);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk) regReq <= '{1'b0, 1'b1, a, d};
    @(posedge clk) regReq <= '0;
  endtask

  // Register read, answer one cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge clk) regReq <= '{1'b1, 1'b0, a, 32'h0000_0000};
    @(posedge clk) regReq <= '0;
    #1;
    check({31'h0000_0000, regRdValid}, 32'h0000_0001, "read valid");
    check(regRdata, exp, "read data");
  endtask

  // One frame report, then the event over the next two cycles
  task automatic frm(bit tx, bit ok, bit grp, bit bc, bit vl,
                     logic [4:0] col, logic [15:0] oct, logic ev);
    logic seen;
    @(posedge clk);
    if (tx) txFrame <= {1'b1, ok, grp, bc, vl, col, oct};
    else rxFrame <= {1'b1, ok, grp, bc, vl, col, oct};
    @(posedge clk) txFrame <= '0;
    rxFrame <= '0;
    #1 seen = statsThresholdEvent;
    @(posedge clk) #1 seen = seen | statsThresholdEvent;
    check({31'h0000_0000, seen}, {31'h0000_0000, ev}, "event");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(mcc_pkg::MCAST_RX_OCT_OFS, 32'h0000_0000);
    rd(mcc_pkg::MCAST_TX_OCT_OFS, 32'h0000_0000);
    rd(mcc_pkg::MULTI_COL_OFS, 32'h0000_0000);
    wr(8'h00, 32'h1234_5678);
    rd(8'h00, 32'h0000_0000);
    $display("test reset done");
    frm(0, 1, 1, 0, 0, 5'h00, 16'h0064, 0);
    rd(mcc_pkg::MCAST_RX_OCT_OFS, 32'h0000_0064);
    frm(0, 1, 1, 0, 1, 5'h00, 16'h003C, 0);
    frm(0, 0, 1, 0, 0, 5'h00, 16'h003C, 0);
    frm(0, 1, 1, 1, 0, 5'h00, 16'h003C, 0);
    rd(mcc_pkg::MCAST_RX_OCT_OFS, 32'h0000_00A4);
    frm(1, 1, 1, 0, 1, 5'h00, 16'h003C, 0);
    frm(1, 1, 1, 1, 0, 5'h00, 16'h003C, 0);
    frm(1, 1, 0, 0, 0, 5'h00, 16'h003C, 0);
    frm(1, 0, 1, 0, 0, 5'h00, 16'h003C, 0);
    rd(mcc_pkg::MCAST_TX_OCT_OFS, 32'h0000_0040);
    $display("test qualify done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) statsCounterMask <= (i < 3) ? 3'h1 << i : 3'h0;
      statsGlobalEnable <= (i < 3);
      frm(0, 1, 1, 0, 0, 5'h00, 16'h0010, 0);
      frm(1, 1, 1, 0, 0, 5'h03, 16'h0010, 0);
      rd(mcc_pkg::MCAST_RX_OCT_OFS, expRx[i]);
      rd(mcc_pkg::MCAST_TX_OCT_OFS, expTx[i]);
      rd(mcc_pkg::MULTI_COL_OFS, expCol[i]);
    end
    @(posedge clk) statsGlobalEnable <= 1'b1;
    $display("test enable done");
    frm(1, 1, 0, 0, 0, 5'h01, 16'h0010, 0);
    rd(mcc_pkg::MULTI_COL_OFS, 32'h0000_0002);
    frm(1, 1, 0, 0, 0, 5'h02, 16'h0010, 0);
    rd(mcc_pkg::MULTI_COL_OFS, 32'h0000_0003);
    wr(mcc_pkg::MULTI_COL_OFS, 32'hFFFF_FFFF);
    frm(1, 1, 0, 0, 0, 5'h02, 16'h0010, 0);
    rd(mcc_pkg::MULTI_COL_OFS, 32'h0000_0000);
    wr(mcc_pkg::MCAST_TX_OCT_OFS, 32'hFFFF_FFF0);
    frm(1, 1, 1, 0, 0, 5'h00, 16'h003C, 0);
    rd(mcc_pkg::MCAST_TX_OCT_OFS, 32'h0000_002C);
    $display("test wrap done");
    wr(mcc_pkg::MCAST_TX_OCT_OFS, 32'hBFFF_FFF0);
    frm(1, 1, 1, 0, 0, 5'h00, 16'h0010, 1);
    frm(1, 1, 1, 0, 0, 5'h00, 16'h0010, 0);
    wr(mcc_pkg::MULTI_COL_OFS, 32'hBFFF_FFFF);
    frm(1, 1, 0, 0, 0, 5'h02, 16'h0010, 1);
    wr(mcc_pkg::MCAST_RX_OCT_OFS, 32'hBFFF_FFFF);
    frm(0, 1, 1, 0, 0, 5'h00, 16'h0001, 1);
    $display("test threshold done");
    @(posedge clk) swReset <= 1'b1;
    @(posedge clk) swReset <= 1'b0;
    rd(mcc_pkg::MCAST_RX_OCT_OFS, 32'h0000_0000);
    rd(mcc_pkg::MCAST_TX_OCT_OFS, 32'h0000_0000);
    rd(mcc_pkg::MULTI_COL_OFS, 32'h0000_0000);
    $display("test soft reset done");
    print_verdict();
  end

  // Watchdog well past the expected run of about 150 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
